// ===== design/lcpc_pkg.sv
// Notes on behaviour
// - start at 8000h; page registers reset 80h
// - privilege level resets to high
// - protect enable resets to one
// - blank system password clears protect enable
// - after boot, execution moves to 0000h
// - system code loads loader page from 0Fh
// - jump to loader base drops privilege medium
// - loader code loads application page from 0Fh
// - jump to application base drops privilege low
// - command F0 returns current context byte
// - command F1 sets context, status reports error
// - default context is least privileged present region
// - only default context password auto-tested; others need unlock
// - programmed word 000Eh sets debug lockout
// - master erase from current context base upward
// - protected commands check current region lock
// - match grants system all, loader user, application own
// - three lock bits; system/loader not register-writable
// - master erase passwordless; extra system/loader erases
// - global command families ignore the context
// - protection enabled disables system code debugging
`default_nettype none
package lcpc_pkg;
   localparam logic [15:0] ROM_START = 16'h8000;
   localparam logic [15:0] SYS_START = 16'h0000;
   localparam logic [7:0] PAGE_RESET = 8'h80;
   localparam logic [7:0] PAGE_ZERO = 8'h00;
   localparam logic [15:0] PTR_WORD = 16'h000f;
   localparam logic [15:0] DBG_WORD = 16'h000e;
   localparam logic [15:0] PW_WORD = 16'h0010;
   localparam logic [3:0] PW_WORDS = 4'h8;
   localparam logic [3:0] ONE_WORD = 4'h1;
   localparam logic [15:0] BLANK_WORD = 16'hffff;
   localparam logic [1:0] CTX_SYS = 2'h0;
   localparam logic [1:0] CTX_LDR = 2'h1;
   localparam logic [1:0] CTX_APP = 2'h2;
   localparam logic [1:0] PRIVILEGE_LEVEL_LOW = 2'h1;
   localparam logic [1:0] PRIVILEGE_LEVEL_MED = 2'h2;
   localparam logic [1:0] PRIVILEGE_LEVEL_HIGH = 2'h3;
   localparam logic [2:0] LOCK_RESET = 3'h7;
   localparam logic [7:0] CMD_STATUS = 8'h01;
   localparam logic [7:0] CMD_ERASE = 8'h02;
   localparam logic [7:0] CMD_UNLOCK = 8'h03;
   localparam logic [7:0] CMD_ACCESS = 8'h04;
   localparam logic [7:0] CMD_GET_CTX = 8'hf0;
   localparam logic [7:0] CMD_SET_CTX = 8'hf1;
   localparam logic [7:0] CMD_ERASE_SYS = 8'hf2;
   localparam logic [7:0] CMD_ERASE_LDR = 8'hf3;
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_CTX = 8'h01;
   localparam logic [7:0] ERR_LOCKED = 8'h02;
   localparam logic [7:0] ERR_BADCMD = 8'h03;
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_PAGES = 8'h04;
   localparam logic [7:0] ADDR_LOCK = 8'h08;
   localparam logic [7:0] ADDR_ERROR = 8'h0c;
   localparam logic [2:0] ADDR_KEY_HI = 3'h1;
   localparam int LOCK_APP_BIT = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   typedef enum logic [2:0] {
      st_boot_pw, st_boot_dbg, st_sys_ptr, st_ldr_ptr, st_def_pw,
      st_idle, st_unlock
   } lcpc_state_t;
endpackage
`default_nettype wire

// ===== design/lcpc_ctrl.sv
`default_nettype none
module lcpc_ctrl (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [15:0] code_pointer,
   output logic code_rd,
   input wire logic [15:0] code_rdata,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] cmd_arg,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic [15:0] exec_addr,
   output logic [1:0] privilege_level,
   output logic protect_enable,
   output logic debug_lockout,
   output logic debug_disable,
   output logic [2:0] password_lock_bits,
   output logic [1:0] region_ctx,
   output logic [7:0] loader_start_page,
   output logic [7:0] app_start_page,
   output logic erase_req,
   output logic [7:0] erase_from_page
);
   lcpc_pkg::lcpc_state_t state, next_state;
   logic [3:0] cnt, next_cnt, nwords;
   logic rd_q, next_rd_q, match, next_match, multi, last, word_ok;
   logic [15:0] next_exec_addr, rd_ofs, cmp_word;
   logic [1:0] next_privilege_level, next_ctx, default_ctx, next_bresp, next_rresp;
   logic next_protect, next_dbg, next_rsp_valid, next_erase_req;
   logic [2:0] next_lock, key_idx;
   logic [7:0] next_ldr_page, next_app_page, err, next_err;
   logic [7:0] next_rsp_data, next_erase_page, ctx_page, def_page, rd_page;
   logic [15:0] key [8], next_key [8];
   logic next_bvalid, next_rvalid;
   logic [31:0] next_rdata;
   logic aw_take, ar_take, lock_wr, key_wr;

   function automatic logic [7:0] page_of(input logic [1:0] c,
                                          input logic [7:0] lp,
                                          input logic [7:0] ap);
      if (c == lcpc_pkg::CTX_LDR) begin
         page_of = lp;
      end else if (c == lcpc_pkg::CTX_APP) begin
         page_of = ap;
      end else begin
         page_of = lcpc_pkg::PAGE_ZERO;
      end
   endfunction

   // least privileged present region is the default
   always_comb begin
      if (app_start_page < lcpc_pkg::PAGE_RESET) begin
         default_ctx = lcpc_pkg::CTX_APP;
      end else if (loader_start_page < lcpc_pkg::PAGE_RESET) begin
         default_ctx = lcpc_pkg::CTX_LDR;
      end else begin
         default_ctx = lcpc_pkg::CTX_SYS;
      end
   end

   assign ctx_page = page_of(region_ctx, loader_start_page, app_start_page);
   assign def_page = page_of(default_ctx, loader_start_page, app_start_page);
   assign debug_disable = debug_lockout | protect_enable;
   assign cmd_ready = (state == lcpc_pkg::st_idle);

   // code memory read port: address out, data back one cycle later
   always_comb begin
      rd_page = lcpc_pkg::PAGE_ZERO;
      rd_ofs = lcpc_pkg::PW_WORD;
      multi = 1'b0;
      unique case (state)
         lcpc_pkg::st_boot_pw: multi = 1'b1;
         lcpc_pkg::st_boot_dbg: rd_ofs = lcpc_pkg::DBG_WORD;
         lcpc_pkg::st_sys_ptr: rd_ofs = lcpc_pkg::PTR_WORD;
         lcpc_pkg::st_ldr_ptr: begin
            rd_page = loader_start_page;
            rd_ofs = lcpc_pkg::PTR_WORD;
         end
         lcpc_pkg::st_def_pw: begin
            rd_page = def_page;
            multi = 1'b1;
         end
         lcpc_pkg::st_unlock: begin
            rd_page = ctx_page;
            multi = 1'b1;
         end
         lcpc_pkg::st_idle: rd_ofs = lcpc_pkg::PW_WORD;
      endcase
      nwords = multi ? lcpc_pkg::PW_WORDS : lcpc_pkg::ONE_WORD;
      code_rd = (state != lcpc_pkg::st_idle) && (cnt < nwords);
      code_pointer = {rd_page, 8'h00} + rd_ofs + {12'h000, cnt};
      key_idx = 3'(cnt - 4'h1);
      cmp_word = (state == lcpc_pkg::st_unlock) ? key[key_idx]
                                                : lcpc_pkg::BLANK_WORD;
      word_ok = (code_rdata == cmp_word);
      last = rd_q && (cnt == nwords);
   end

   // boot sequence and command interpreter
   always_comb begin
      next_state = state;
      next_cnt = code_rd ? cnt + 4'h1 : cnt;
      next_rd_q = code_rd;
      next_match = rd_q ? (match & word_ok) : match;
      next_exec_addr = exec_addr;
      next_privilege_level = privilege_level;
      next_protect = protect_enable;
      next_dbg = debug_lockout;
      next_lock = password_lock_bits;
      next_ctx = region_ctx;
      next_ldr_page = loader_start_page;
      next_app_page = app_start_page;
      next_err = err;
      next_rsp_valid = 1'b0;
      next_rsp_data = rsp_data;
      next_erase_req = 1'b0;
      next_erase_page = erase_from_page;
      if (lock_wr) begin
         next_lock[lcpc_pkg::LOCK_APP_BIT] =
            s_axi_wdata[lcpc_pkg::LOCK_APP_BIT];
      end
      if (last) begin
         next_cnt = 4'h0;
         next_match = 1'b1;
      end
      unique case (state)
         lcpc_pkg::st_boot_pw: if (last) begin
            if (match & word_ok) begin
               next_protect = 1'b0;
            end
            next_state = lcpc_pkg::st_boot_dbg;
         end
         lcpc_pkg::st_boot_dbg: if (last) begin
            next_dbg = (code_rdata != lcpc_pkg::BLANK_WORD);
            next_exec_addr = lcpc_pkg::SYS_START;
            next_state = lcpc_pkg::st_sys_ptr;
         end
         lcpc_pkg::st_sys_ptr: if (last) begin
            next_ldr_page = code_rdata[7:0];
            next_state = lcpc_pkg::st_def_pw;
            if (code_rdata[7:0] < lcpc_pkg::PAGE_RESET) begin
               next_exec_addr = {code_rdata[7:0], 8'h00};
               next_privilege_level = lcpc_pkg::PRIVILEGE_LEVEL_MED;
               next_state = lcpc_pkg::st_ldr_ptr;
            end
         end
         lcpc_pkg::st_ldr_ptr: if (last) begin
            next_app_page = code_rdata[7:0];
            next_state = lcpc_pkg::st_def_pw;
            if (code_rdata[7:0] < lcpc_pkg::PAGE_RESET) begin
               next_exec_addr = {code_rdata[7:0], 8'h00};
               next_privilege_level = lcpc_pkg::PRIVILEGE_LEVEL_LOW;
            end
         end
         lcpc_pkg::st_def_pw: if (last) begin
            next_ctx = default_ctx;
            if (match & word_ok) begin
               next_lock[default_ctx] = 1'b0;
            end
            next_state = lcpc_pkg::st_idle;
         end
         lcpc_pkg::st_unlock: if (last) begin
            next_rsp_valid = 1'b1;
            if (match & word_ok) begin
               next_lock[region_ctx] = 1'b0;
               next_err = lcpc_pkg::ERR_NONE;
               next_rsp_data = lcpc_pkg::ERR_NONE;
            end else begin
               next_lock[region_ctx] = 1'b1;
               next_err = lcpc_pkg::ERR_LOCKED;
               next_rsp_data = lcpc_pkg::ERR_LOCKED;
            end
            next_state = lcpc_pkg::st_idle;
         end
         lcpc_pkg::st_idle: if (cmd_valid) begin
            next_rsp_valid = 1'b1;
            next_rsp_data = lcpc_pkg::ERR_NONE;
            next_err = lcpc_pkg::ERR_NONE;
            next_cnt = 4'h0;
            unique case (cmd_code)
               lcpc_pkg::CMD_STATUS: begin
                  next_err = err;
                  next_rsp_data = err;
               end
               lcpc_pkg::CMD_GET_CTX:
                  next_rsp_data = {6'h00, region_ctx};
               lcpc_pkg::CMD_SET_CTX:
                  if (cmd_arg <= {6'h00, lcpc_pkg::CTX_APP}) begin
                     next_ctx = cmd_arg[1:0];
                  end else begin
                     next_err = lcpc_pkg::ERR_CTX;
                     next_rsp_data = lcpc_pkg::ERR_CTX;
                  end
               lcpc_pkg::CMD_ERASE: begin
                  next_erase_req = 1'b1;
                  next_erase_page = ctx_page;
               end
               lcpc_pkg::CMD_ERASE_SYS: begin
                  next_erase_req = 1'b1;
                  next_erase_page = lcpc_pkg::PAGE_ZERO;
               end
               lcpc_pkg::CMD_ERASE_LDR: begin
                  next_erase_req = 1'b1;
                  next_erase_page = loader_start_page;
               end
               lcpc_pkg::CMD_UNLOCK: begin
                  next_rsp_valid = 1'b0;
                  next_state = lcpc_pkg::st_unlock;
               end
               lcpc_pkg::CMD_ACCESS:
                  if (!password_lock_bits[region_ctx]
                      && cmd_arg >= ctx_page) begin
                     next_rsp_data = 8'h01;
                  end else begin
                     next_err = lcpc_pkg::ERR_LOCKED;
                     next_rsp_data = 8'h00;
                  end
               default: begin
                  next_err = lcpc_pkg::ERR_BADCMD;
                  next_rsp_data = lcpc_pkg::ERR_BADCMD;
               end
            endcase
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= lcpc_pkg::st_boot_pw;
         cnt <= 4'h0;
         rd_q <= 1'b0;
         match <= 1'b1;
         exec_addr <= lcpc_pkg::ROM_START;
         privilege_level <= lcpc_pkg::PRIVILEGE_LEVEL_HIGH;
         protect_enable <= 1'b1;
         debug_lockout <= 1'b0;
         password_lock_bits <= lcpc_pkg::LOCK_RESET;
         region_ctx <= lcpc_pkg::CTX_SYS;
         loader_start_page <= lcpc_pkg::PAGE_RESET;
         app_start_page <= lcpc_pkg::PAGE_RESET;
         err <= lcpc_pkg::ERR_NONE;
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
         erase_req <= 1'b0;
         erase_from_page <= 8'h00;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         rd_q <= next_rd_q;
         match <= next_match;
         exec_addr <= next_exec_addr;
         privilege_level <= next_privilege_level;
         protect_enable <= next_protect;
         debug_lockout <= next_dbg;
         password_lock_bits <= next_lock;
         region_ctx <= next_ctx;
         loader_start_page <= next_ldr_page;
         app_start_page <= next_app_page;
         err <= next_err;
         rsp_valid <= next_rsp_valid;
         rsp_data <= next_rsp_data;
         erase_req <= next_erase_req;
         erase_from_page <= next_erase_page;
      end
   end

   // register slave: one write and one read in flight at most
   assign aw_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = aw_take;
   assign s_axi_wready = aw_take;
   assign ar_take = s_axi_arvalid & ~s_axi_rvalid;
   assign s_axi_arready = ar_take;
   assign lock_wr = aw_take && (s_axi_awaddr == lcpc_pkg::ADDR_LOCK)
                    && s_axi_wstrb[0];
   assign key_wr = aw_take && (s_axi_awaddr[7:5] == lcpc_pkg::ADDR_KEY_HI)
                   && (s_axi_awaddr[1:0] == 2'h0);

   always_comb begin
      next_key = key;
      next_bvalid = s_axi_bvalid & ~s_axi_bready;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid & ~s_axi_rready;
      next_rresp = s_axi_rresp;
      next_rdata = s_axi_rdata;
      if (aw_take) begin
         next_bvalid = 1'b1;
         next_bresp = lcpc_pkg::RESP_OKAY;
         if (key_wr) begin
            if (s_axi_wstrb[0]) begin
               next_key[s_axi_awaddr[4:2]][7:0] = s_axi_wdata[7:0];
            end
            if (s_axi_wstrb[1]) begin
               next_key[s_axi_awaddr[4:2]][15:8] = s_axi_wdata[15:8];
            end
         end else if (s_axi_awaddr != lcpc_pkg::ADDR_STATUS
                      && s_axi_awaddr != lcpc_pkg::ADDR_PAGES
                      && s_axi_awaddr != lcpc_pkg::ADDR_LOCK
                      && s_axi_awaddr != lcpc_pkg::ADDR_ERROR) begin
            next_bresp = lcpc_pkg::RESP_DECERR;
         end
      end
      if (ar_take) begin
         next_rvalid = 1'b1;
         next_rresp = lcpc_pkg::RESP_OKAY;
         next_rdata = 32'h0000_0000;
         if (s_axi_araddr == lcpc_pkg::ADDR_STATUS) begin
            next_rdata[7:0] = {cmd_ready, debug_disable, debug_lockout,
                               protect_enable, privilege_level, region_ctx};
         end else if (s_axi_araddr == lcpc_pkg::ADDR_PAGES) begin
            next_rdata[15:0] = {app_start_page, loader_start_page};
         end else if (s_axi_araddr == lcpc_pkg::ADDR_LOCK) begin
            next_rdata[2:0] = password_lock_bits;
         end else if (s_axi_araddr == lcpc_pkg::ADDR_ERROR) begin
            next_rdata = {exec_addr, 8'h00, err};
         end else if (s_axi_araddr[7:5] == lcpc_pkg::ADDR_KEY_HI
                      && s_axi_araddr[1:0] == 2'h0) begin
            next_rdata[15:0] = key[s_axi_araddr[4:2]];
         end else begin
            next_rresp = lcpc_pkg::RESP_DECERR;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         for (int i = 0; i < 8; i++) begin
            key[i] <= 16'h0000;
         end
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h0000_0000;
      end else begin
         key <= next_key;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// ===== dv/lcpc_ctrl_props.sv
`default_nettype none
module lcpc_ctrl_props (
   input wire logic mclk,
   input wire logic reset,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] cmd_arg,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_data,
   input wire logic [15:0] exec_addr,
   input wire logic [1:0] privilege_level,
   input wire logic protect_enable,
   input wire logic debug_lockout,
   input wire logic debug_disable,
   input wire logic [2:0] password_lock_bits,
   input wire logic [1:0] region_ctx,
   input wire logic [7:0] loader_start_page,
   input wire logic [7:0] app_start_page,
   input wire logic erase_req,
   input wire logic [7:0] erase_from_page
);
   logic take;
   logic lock_now;
   logic [1:0] arg_lo;
   logic [7:0] ctx_page;
   assign take = cmd_valid && cmd_ready;
   assign arg_lo = cmd_arg[1:0];
   assign lock_now = password_lock_bits[region_ctx];
   assign ctx_page = (region_ctx == 2'h0) ? 8'h00 :
      (region_ctx == 2'h1) ? loader_start_page : app_start_page;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (reset);
   rst_page_a:
      assert property ($fell(reset) |-> exec_addr == 16'h8000 &&
         loader_start_page == 8'h80 && app_start_page == 8'h80)
      else $error("start address or pages wrong after reset");
   rst_privilege_level_a:
      assert property ($fell(reset) |-> privilege_level == 2'h3)
      else $error("privilege not high after reset");
   rst_prot_a:
      assert property ($fell(reset) |-> protect_enable)
      else $error("protection off after reset");
   dbg_gate_a:
      assert property (debug_disable == (protect_enable || debug_lockout))
      else $error("debug gate wrong");
   ldr_drop_a:
      assert property ($changed(exec_addr) && !$past(reset) &&
         loader_start_page < 8'h80 && exec_addr == {loader_start_page, 8'h00}
         |-> ##[0:1] privilege_level == 2'h2)
      else $error("loader jump kept privilege");
   app_drop_a:
      assert property ($changed(exec_addr) && !$past(reset) &&
         app_start_page < 8'h80 && exec_addr == {app_start_page, 8'h00}
         |-> ##[0:1] privilege_level == 2'h1)
      else $error("application jump kept privilege");
   get_ctx_a:
      assert property (take && cmd_code == 8'hf0 |=> rsp_valid &&
         rsp_data == {6'h00, $past(region_ctx)})
      else $error("context read wrong");
   set_ctx_a:
      assert property (take && cmd_code == 8'hf1 && cmd_arg < 8'h03 |=>
         region_ctx == $past(arg_lo) && rsp_data == 8'h00)
      else $error("context write wrong");
   bad_ctx_a:
      assert property (take && cmd_code == 8'hf1 && cmd_arg > 8'h02 |=>
         $stable(region_ctx) && rsp_valid && rsp_data == 8'h01)
      else $error("bad context accepted");
   erase_ctx_a:
      assert property (take && cmd_code == 8'h02 |=> erase_req &&
         erase_from_page == $past(ctx_page))
      else $error("master erase base wrong");
   erase_sys_a:
      assert property (take && cmd_code == 8'hf2 |=> erase_req &&
         erase_from_page == 8'h00)
      else $error("system erase base wrong");
   access_gate_a:
      assert property (take && cmd_code == 8'h04 |=> rsp_valid &&
         rsp_data == ((!$past(lock_now) && $past(cmd_arg) >= $past(ctx_page))
         ? 8'h01 : 8'h00))
      else $error("access grant wrong");
   boot_jump_a:
      assert property ($changed(exec_addr) && $past(exec_addr) == 16'h8000
         |-> exec_addr == 16'h0000) else $error("boot exit wrong");
   cover property (take && cmd_code == 8'h03);
   cover property (erase_req);
   cover property (privilege_level == 2'h1);
endmodule
bind lcpc_ctrl lcpc_ctrl_props u_props (.mclk, .reset, .cmd_valid,
   .cmd_ready, .cmd_code, .cmd_arg, .rsp_valid, .rsp_data, .exec_addr,
   .privilege_level, .protect_enable, .debug_lockout, .debug_disable,
   .password_lock_bits, .region_ctx, .loader_start_page, .app_start_page,
   .erase_req, .erase_from_page);
`default_nettype wire

// ===== dv/lcpc_boot_master.sv
`default_nettype none
module lcpc_boot_master (
   input wire logic mclk,
   input wire logic cmd_ready,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic [7:0] cmd_arg,
   input wire logic [15:0] code_pointer,
   input wire logic code_rd,
   output logic [15:0] code_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:65535];
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      cmd_arg = 8'h00;
      code_rdata = 16'h0000;
   end
   // word one cycle after the strobe, churning otherwise
   always @(posedge mclk) begin
      if (code_rd === 1'b1)
         code_rdata <= mem[code_pointer];
      else
         code_rdata <= ~code_rdata;
   end
   // one command, held until taken, then scrambled
   task automatic issue(input logic [7:0] c, input logic [7:0] a,
      input int gap);
      @(posedge mclk);
      repeat (gap) @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_arg <= a;
      do @(posedge mclk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      cmd_code <= ~c;
      cmd_arg <= ~a;
   endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, code_rd, cmd_valid;
   logic cmd_ready, rsp_valid, protect_enable, debug_lockout;
   logic debug_disable, erase_req;
   logic [7:0] s_axi_awaddr, s_axi_araddr, cmd_code, cmd_arg, rsp_data;
   logic [7:0] loader_start_page, app_start_page, erase_from_page;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, privilege_level, region_ctx;
   logic [15:0] code_pointer, code_rdata, exec_addr;
   logic [2:0] password_lock_bits;
   logic [15:0] lpw [0:7];
   logic [33:0] re;
   logic [33:0] rq[$];
   logic [7:0] cq[$], eq[$];
   logic [1:0] bq[$];
   int err_total, checked;
   lcpc_ctrl DUT (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .code_pointer, .code_rd,
      .code_rdata, .cmd_valid, .cmd_ready, .cmd_code, .cmd_arg, .rsp_valid,
      .rsp_data, .exec_addr, .privilege_level, .protect_enable,
      .debug_lockout, .debug_disable, .password_lock_bits, .region_ctx,
      .loader_start_page, .app_start_page, .erase_req, .erase_from_page);
   lcpc_boot_master far (.mclk, .cmd_ready, .cmd_valid, .cmd_code,
      .cmd_arg, .code_pointer, .code_rd, .code_rdata);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
      bq.push_back(r);
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge mclk); while ((s_axi_awready & s_axi_wready) !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      rq.push_back(e);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge mclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask
   task automatic cmd(input logic [7:0] c, input logic [7:0] a,
      input logic [7:0] e);
      cq.push_back(e);
      far.issue(c, a, int'(xs() % 3));
   endtask
   task automatic keys(input logic use_lpw);
      for (int i = 0; i < 8; i++)
         wr(8'(32'h20 + 4 * i), {16'h0000, use_lpw ? lpw[i] : 16'hffff}, 2'h0);
   endtask
   task automatic boot();
      reset <= 1'b1;
      repeat (7) @(posedge mclk);
      #1;
      chk("exec_addr", {16'h0, exec_addr}, 32'h8000);
      chk("pages", {16'h0, loader_start_page, app_start_page}, 32'h8080);
      chk("privilege_level", {30'h0, privilege_level}, 32'h3);
      chk("protect", {31'h0, protect_enable}, 32'h1);
      @(posedge mclk);
      reset <= 1'b0;
      for (int i = 0; i < 300 && cmd_ready !== 1'b1; i++) @(posedge mclk);
   endtask
   always @(posedge mclk) begin
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
         chk("bresp", {30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         re = rq.pop_front();
         chk("rresp", {30'h0, s_axi_rresp}, {30'h0, re[33:32]});
         if (re[33:32] == 2'h0)
            chk("rdata", s_axi_rdata, re[31:0]);
      end
      if (rsp_valid === 1'b1)
         chk("rsp", {24'h0, rsp_data}, {24'h0, cq.pop_front()});
      if (erase_req === 1'b1)
         chk("erase", {24'h0, erase_from_page}, {24'h0, eq.pop_front()});
   end
   initial begin
      #200000;
      err_total++;
      print_verdict();
   end
   initial begin
      reset = 1'b1;
      seed = 32'd20055;
      err_total = 0;
      checked = 0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      for (int i = 0; i < 65536; i++)
         far.mem[i] = 16'hffff;
      far.mem[16'h000e] = 16'h1234;
      far.mem[16'h000f] = 16'h0010;
      far.mem[16'h100f] = 16'h0020;
      for (int i = 0; i < 8; i++) begin
         lpw[i] = 16'(xs());
         far.mem[16'h1010 + i] = lpw[i];
      end
      boot();
      rd(8'h00, {2'h0, 32'h0000_00e6});
      rd(8'h04, {2'h0, 32'h0000_2010});
      rd(8'h08, {2'h0, 32'h3});
      rd(8'h0c, {2'h0, 32'h2000_0000});
      rd(8'h40, {2'h3, 32'h0});
      wr(8'h44, 32'h1, 2'h3);
      wr(8'h08, 32'h4, 2'h0);
      cmd(8'hf0, 8'h00, 8'h02);
      cmd(8'h04, 8'h20, 8'h00);
      cmd(8'h01, 8'h00, 8'h02);
      keys(1'b0);
      cmd(8'h03, 8'h00, 8'h00);
      cmd(8'h04, 8'h20, 8'h01);
      cmd(8'h04, 8'h1f, 8'h00);
      cmd(8'hf1, 8'h05, 8'h01);
      cmd(8'h01, 8'h00, 8'h01);
      cmd(8'hf0, 8'h00, 8'h02);
      cmd(8'hf1, 8'h01, 8'h00);
      cmd(8'h03, 8'h00, 8'h02);
      rd(8'h08, {2'h0, 32'h3});
      keys(1'b1);
      cmd(8'h03, 8'h00, 8'h00);
      cmd(8'h04, 8'h10, 8'h01);
      for (int c = 0; c < 3; c++) begin
         cmd(8'hf1, 8'(c), 8'h00);
         cmd(8'hf0, 8'h00, 8'(c));
         eq.push_back(8'(c * 16));
         cmd(8'h02, 8'h00, 8'h00);
         eq.push_back(8'h00);
         cmd(8'hf2, 8'h00, 8'h00);
         eq.push_back(8'h10);
         cmd(8'hf3, 8'h00, 8'h00);
      end
      cmd(8'hf1, 8'h00, 8'h00);
      cmd(8'h04, 8'h00, 8'h00);
      keys(1'b0);
      cmd(8'h03, 8'h00, 8'h00);
      cmd(8'h04, 8'h00, 8'h01);
      for (int i = 0; i < 65536; i++)
         far.mem[i] = 16'hffff;
      far.mem[16'h0010] = 16'h5a5a;
      far.mem[16'h000f] = 16'h0030;
      boot();
      rd(8'h00, {2'h0, 32'h0000_00d9});
      rd(8'h08, {2'h0, 32'h5});
      rd(8'h0c, {2'h0, 32'h3000_0000});
      cmd(8'hf0, 8'h00, 8'h01);
      cmd(8'h77, 8'h00, 8'h03);
      repeat (4) @(posedge mclk);
      chk("left", cq.size() + eq.size() + rq.size() + bq.size(), 0);
      print_verdict();
   end
endmodule
`default_nettype wire
